// ==== hw/sync_burst_sram_port.sv ====
// synchronous burst sram device with flow-through reads
`timescale 1ns/10ps
module sync_burst_sram_port (
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_n,
  input  wire logic                                  stall_input_n,
  input  wire logic                                  advance_or_load,
  input  wire logic                                  read_not_write,
  input  wire logic                                  select_a_n,
  input  wire logic                                  select_b,
  input  wire logic                                  select_c_n,
  input  wire logic                                  burst_order_select,
  input  wire logic                                  out_enable_n,
  input  wire logic [sram_port_pkg::LANES-1:0]       byte_lane_write_n,
  input  wire logic [sram_port_pkg::ADDR_W-1:0]      word_addr_in,
  input  wire logic [sram_port_pkg::DATA_W-1:0]      data_lines_in,
  input  wire logic [sram_port_pkg::PAR_W-1:0]       parity_lines_in,
  output logic      [sram_port_pkg::DATA_W-1:0]      data_lines_out,
  output logic      [sram_port_pkg::PAR_W-1:0]       parity_lines_out,
  output logic      [sram_port_pkg::DATA_W-1:0]      data_lines_oe_n,
  output logic      [sram_port_pkg::PAR_W-1:0]       parity_lines_oe_n
);
  import sram_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // burst address function
  function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
                                                   input logic [CNT_W-1:0]  cnt,
                                                   input logic              ilv);
    logic [CNT_W-1:0] low;
    low = ilv ? (base[CNT_W-1:0] ^ cnt) : CNT_W'(base[CNT_W-1:0] + cnt);
    return {base[ADDR_W-1:CNT_W], low};
  endfunction : burst_addr

  ////////////////////////////////////////////////////////////////////////////
  // control decode
  logic                 selected;
  logic                 run;
  logic                 load_op;
  logic                 deselect_op;
  logic                 adv_op;
  logic                 burst_live_r;
  logic                 burst_rd_r;
  logic [ADDR_W-1:0]    base_r;
  logic [CNT_W-1:0]     cnt_r;
  logic [CNT_W-1:0]     cnt_nxt;
  logic                 ilv_r;
  logic                 dat_valid_r;
  logic                 dat_rd_r;
  logic [ADDR_W-1:0]    dat_addr_r;
  logic [LANES-1:0]     dat_be_n_r;
  logic [WORD_W-1:0]    mem [DEPTH];
  logic [WORD_W-1:0]    rd_word;
  logic                 drive;
  logic [CNT_W:0]       words_r;

  assign selected    = !select_a_n && select_b && !select_c_n;
  assign run         = !stall_input_n;
  assign load_op     = run && !advance_or_load && selected;
  assign deselect_op = run && !advance_or_load && !selected;
  assign adv_op      = run && advance_or_load && burst_live_r && (cnt_r != CNT_LAST);
  assign cnt_nxt     = CNT_W'(cnt_r + 2'h1);

  ////////////////////////////////////////////////////////////////////////////
  // address and burst registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      base_r <= ADDR_RST;
      ilv_r  <= 1'b0;
    end else if (load_op) begin
      base_r <= word_addr_in;
      ilv_r  <= burst_order_select;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= CNT_RST;
    end else if (load_op) begin
      cnt_r <= CNT_RST;
    end else if (adv_op) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      burst_live_r <= 1'b0;
    end else if (load_op) begin
      burst_live_r <= 1'b1;
    end else if (deselect_op) begin
      burst_live_r <= 1'b0;
    end else if (run && advance_or_load && !adv_op) begin
      burst_live_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      burst_rd_r <= 1'b0;
    end else if (load_op) begin
      burst_rd_r <= read_not_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data cycle registers, one clock behind the address cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dat_valid_r <= 1'b0;
    end else if (run) begin
      dat_valid_r <= load_op || adv_op;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dat_be_n_r <= '1;
    end else if (run) begin
      dat_be_n_r <= byte_lane_write_n;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dat_rd_r <= 1'b0;
    end else if (load_op) begin
      dat_rd_r <= read_not_write;
    end else if (adv_op) begin
      dat_rd_r <= burst_rd_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dat_addr_r <= ADDR_RST;
    end else if (load_op) begin
      dat_addr_r <= burst_addr(word_addr_in, CNT_RST, 1'b0);
    end else if (adv_op) begin
      dat_addr_r <= burst_addr(base_r, cnt_nxt, ilv_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // words handed out by the current burst, watched by the checks
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      words_r <= '0;
    end else if (load_op) begin
      words_r <= {{CNT_W{1'b0}}, 1'b1};
    end else if (deselect_op) begin
      words_r <= '0;
    end else if (adv_op) begin
      words_r <= words_r + {{CNT_W{1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array: write data registered at the end of its data cycle
  always_ff @(posedge clk_sys) begin
    if (run && dat_valid_r && !dat_rd_r) begin
      for (int i = 0; i < LANES; i++) begin
        if (!dat_be_n_r[i]) begin
          mem[dat_addr_r][i*LANE_W +: LANE_W] <=
            {parity_lines_in[i], data_lines_in[i*8 +: 8]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flow-through read path and asynchronous output enable
  assign rd_word = mem[dat_addr_r];
  assign drive   = dat_valid_r && dat_rd_r && !out_enable_n;

  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      data_lines_out[i*8 +: 8] = rd_word[i*LANE_W +: 8];
      parity_lines_out[i]      = rd_word[i*LANE_W + 8];
    end
  end

  assign data_lines_oe_n   = {DATA_W{!drive}};
  assign parity_lines_oe_n = {PAR_W{!drive}};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_load_to_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_op |=> dat_valid_r && dat_addr_r == $past(word_addr_in))
    else $error("load not followed by data cycle");

  chk_stall_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !run |=> $stable(base_r) && $stable(cnt_r) && $stable(dat_valid_r) && $stable(dat_addr_r))
    else $error("state changed during stall");

  chk_stall_outputs: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !run && $stable(out_enable_n) |=> $stable(data_lines_oe_n))
    else $error("outputs moved on stalled edge");

  chk_deselect_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
    deselect_op |=> !burst_live_r)
    else $error("burst survived deselect");

  chk_pending_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    deselect_op && burst_live_r && $past(load_op) |-> dat_valid_r)
    else $error("pending transfer cancelled");

  chk_bus_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (deselect_op || (load_op && !read_not_write)) |=> data_lines_oe_n == '1)
    else $error("bus not released after deselect or write");

  chk_oe_async: assert property (@(posedge clk_sys) disable iff (!rst_n)
    out_enable_n |-> data_lines_oe_n == '1 && parity_lines_oe_n == '1)
    else $error("bus driven while output disabled");

  chk_burst_four: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_op ##1 (run && advance_or_load)[*3] |=> dat_valid_r && cnt_r == CNT_LAST)
    else $error("burst did not reach four words");

  chk_burst_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adv_op |=> dat_addr_r[ADDR_W-1:CNT_W] == base_r[ADDR_W-1:CNT_W])
    else $error("burst changed upper address bits");

  chk_read_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_op && read_not_write && !out_enable_n ##1 !out_enable_n |-> data_lines_oe_n == '0)
    else $error("read data not driven in data cycle");

  chk_load_addr_cap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_op |=> base_r == $past(word_addr_in))
    else $error("address not captured on load");

  chk_addr_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !load_op |=> $stable(base_r))
    else $error("address moved without load");

  chk_order_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_op |=> ilv_r == $past(burst_order_select))
    else $error("burst order not captured on load");

  chk_cnt_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_op |=> cnt_r == CNT_RST && burst_live_r)
    else $error("load did not start a burst");

  chk_cnt_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adv_op |=> CNT_W'(cnt_r - $past(cnt_r)) == 2'h1)
    else $error("advance did not step counter");

  chk_cnt_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && advance_or_load && !adv_op |=> $stable(cnt_r))
    else $error("counter moved without advance");

  chk_adv_addr_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && advance_or_load |=> $stable(base_r))
    else $error("address pins used on advance");

  chk_last_stops: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && advance_or_load && cnt_r == CNT_LAST |=> !dat_valid_r && !burst_live_r)
    else $error("burst ran past four words");

  chk_adv_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && advance_or_load && !burst_live_r |=> !dat_valid_r)
    else $error("advance without burst made a transfer");

  chk_rd_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_op |=> dat_rd_r == $past(read_not_write) && burst_rd_r == $past(read_not_write))
    else $error("read or write not taken on load");

  chk_rd_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adv_op |=> dat_rd_r == burst_rd_r)
    else $error("burst changed direction");

  chk_adv_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adv_op |=> dat_valid_r)
    else $error("advance not followed by data cycle");

  chk_desel_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    deselect_op |=> !dat_valid_r && words_r == '0)
    else $error("deselect started a transfer");

  chk_sel_any: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && !advance_or_load && (select_a_n || !select_b || select_c_n) |=> !burst_live_r)
    else $error("single inactive select did not deselect");

  chk_write_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dat_valid_r && !dat_rd_r |-> data_lines_oe_n == '1)
    else $error("bus driven during write data cycle");

  chk_no_drive_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !dat_valid_r |-> data_lines_oe_n == '1)
    else $error("bus driven with no data cycle");

  chk_read_drive_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dat_valid_r && dat_rd_r && !out_enable_n |-> data_lines_oe_n == '0)
    else $error("read data cycle not driven");

  chk_parity_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    data_lines_oe_n[0] == parity_lines_oe_n[0])
    else $error("parity lines drive apart from data lines");

  chk_lin_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adv_op && !ilv_r |=> CNT_W'(dat_addr_r[CNT_W-1:0] - base_r[CNT_W-1:0]) == cnt_r)
    else $error("linear burst address wrong");

  chk_ilv_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adv_op && ilv_r |=> (dat_addr_r[CNT_W-1:0] ^ base_r[CNT_W-1:0]) == cnt_r)
    else $error("interleaved burst address wrong");

  chk_load_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_op |=> dat_addr_r == base_r)
    else $error("first burst word not at start address");

  chk_load_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_op |=> dat_addr_r[ADDR_W-1:CNT_W] == $past(word_addr_in[ADDR_W-1:CNT_W]))
    else $error("upper address bits lost on load");

  chk_stall_ctrl: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !run |=> $stable(burst_live_r) && $stable(dat_rd_r) && $stable(dat_be_n_r) && $stable(ilv_r))
    else $error("control state changed during stall");

  chk_stall_words: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !run |=> $stable(words_r) && $stable(burst_rd_r))
    else $error("burst progress changed during stall");

  chk_be_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run |=> dat_be_n_r == $past(byte_lane_write_n))
    else $error("byte write selects not captured");

  chk_turn_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dat_valid_r && !dat_rd_r && load_op && read_not_write ##1 !out_enable_n
      |-> data_lines_oe_n == '0)
    else $error("read after write not driven at once");

  chk_burst_words: assert property (@(posedge clk_sys) disable iff (!rst_n)
    words_r <= {1'b1, CNT_RST})
    else $error("burst gave more than four words");

  chk_words_valid: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dat_valid_r |-> words_r != '0)
    else $error("data cycle outside any burst");

  chk_words_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adv_op |=> words_r != $past(words_r))
    else $error("advance did not count a word");
endmodule : sync_burst_sram_port

// ==== inc/sram_port_pkg.sv ====
// shared constants for the synchronous burst sram port
// How it works
// - address cycle, then data cycle next clock
// - read data flows from array, no output register
// - output enable acts without clock, forces release
// - stall high: inputs other than output enable ignored, registers hold
// - stalled edge leaves outputs as if absent
// - deselect on load starts nothing, ends burst
// - pending data cycle still completes after deselect
// - bus released one cycle after deselect or write
// - one load gives four-word burst
// - burst order select picks sequence
// - load with chip selected captures address, control
// - advance ignores address pins, steps counter
// - address loads only on load, unstalled, selected
// - read-not-write on load picks operation
// - array is 131072 words of 36 bits
// - bus is 32 data plus 4 parity lines
// - read and write alternate with no idle cycle
// - address, control and write data are registered
// - select high interleaved, low linear
// - byte write selects per 9-bit byte, writes only
// - select b active high, others active low
package sram_port_pkg;
  localparam int ADDR_W  = 17;
  localparam int DEPTH   = 131072;
  localparam int DATA_W  = 32;
  localparam int PAR_W   = 4;
  localparam int WORD_W  = 36;
  localparam int LANES   = 4;
  localparam int LANE_W  = 9;
  localparam int CNT_W   = 2;
  localparam logic [CNT_W-1:0] CNT_RST  = 2'h0;
  localparam logic [CNT_W-1:0] CNT_LAST = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
endpackage : sram_port_pkg

// ==== bench/ctl_model.sv ====
// controller model driving the sram port from the far side
`timescale 1ns/10ps
module ctl_model (
  input  wire logic                             clk_sys,
  output logic                                  stall_input_n,
  output logic                                  advance_or_load,
  output logic                                  read_not_write,
  output logic                                  select_a_n,
  output logic                                  select_b,
  output logic                                  select_c_n,
  output logic                                  burst_order_select,
  output logic [sram_port_pkg::LANES-1:0]       byte_lane_write_n,
  output logic [sram_port_pkg::ADDR_W-1:0]      word_addr_in,
  output logic [sram_port_pkg::DATA_W-1:0]      data_lines_in,
  output logic [sram_port_pkg::PAR_W-1:0]       parity_lines_in
);
  import sram_port_pkg::*;
  initial begin
    {stall_input_n, advance_or_load, read_not_write, burst_order_select} = 4'h2;
    {select_a_n, select_b, select_c_n} = 3'h7;
    byte_lane_write_n = 4'hf;
    word_addr_in = ADDR_RST;
    {parity_lines_in, data_lines_in} = 36'h0;
  end
  // one unstalled cycle, changed just after the falling edge
  task automatic cyc(input logic adv, input logic rnw, input logic [2:0] sel,
                     input logic [ADDR_W-1:0] a, input logic [LANES-1:0] be,
                     input logic [WORD_W-1:0] wd);
    @(negedge clk_sys);
    stall_input_n <= 1'b0;
    advance_or_load <= adv;
    read_not_write <= rnw;
    {select_a_n, select_b, select_c_n} <= sel;
    word_addr_in <= adv ? ~a : a;
    byte_lane_write_n <= be;
    {parity_lines_in, data_lines_in} <= wd;
  endtask : cyc
  // stalled edge with advance, address and write data inputs scrambled
  task automatic stall();
    @(negedge clk_sys);
    stall_input_n <= 1'b1;
    advance_or_load <= ~advance_or_load;
    word_addr_in <= ~word_addr_in;
    {parity_lines_in, data_lines_in} <= ~{parity_lines_in, data_lines_in};
  endtask : stall
endmodule : ctl_model

// ==== bench/sync_burst_sram_port_tb_top.sv ====
// testbench for the synchronous burst sram port
`timescale 1ns/10ps
module sync_burst_sram_port_tb_top;
  import sram_port_pkg::*;
  localparam logic [2:0]        SEL  = 3'h2;
  localparam logic [ADDR_W-1:0] BASE = 17'h12348;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic out_enable_n = 1'b0;
  logic stall_input_n, advance_or_load, read_not_write, burst_order_select;
  logic select_a_n, select_b, select_c_n;
  logic [LANES-1:0]  byte_lane_write_n;
  logic [ADDR_W-1:0] word_addr_in;
  logic [DATA_W-1:0] data_lines_in, data_lines_out, data_lines_oe_n;
  logic [PAR_W-1:0]  parity_lines_in, parity_lines_out, parity_lines_oe_n;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  sync_burst_sram_port sync_burst_sram_port_i (
    .clk_sys, .rst_n, .stall_input_n, .advance_or_load, .read_not_write,
    .select_a_n, .select_b, .select_c_n, .burst_order_select, .out_enable_n,
    .byte_lane_write_n, .word_addr_in, .data_lines_in, .parity_lines_in,
    .data_lines_out, .parity_lines_out, .data_lines_oe_n, .parity_lines_oe_n);
  ctl_model ctl_model_i (
    .clk_sys, .stall_input_n, .advance_or_load, .read_not_write, .select_a_n,
    .select_b, .select_c_n, .burst_order_select, .byte_lane_write_n,
    .word_addr_in, .data_lines_in, .parity_lines_in);
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [WORD_W-1:0] wv(input int i);
    return 36'h9_0000_00a0 + 36'(i);
  endfunction : wv
  task automatic cmp(input string what, input logic [WORD_W-1:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic look(input logic drv, input logic [WORD_W-1:0] exp);
    #1;
    cmp("bus enable", {WORD_W{~drv}}, {parity_lines_oe_n, data_lines_oe_n});
    if (drv) cmp("read data", exp, {parity_lines_out, data_lines_out});
  endtask : look
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_turn();
    ctl_model_i.cyc(1'b0, 1'b0, SEL, BASE, 4'h0, 36'h0);
    ctl_model_i.cyc(1'b0, 1'b1, SEL, BASE, 4'hf, wv(7));
    look(1'b0, 36'h0);
    ctl_model_i.cyc(1'b0, 1'b1, 3'h7, BASE, 4'hf, 36'h0);
    look(1'b1, wv(7));
    ctl_model_i.cyc(1'b1, 1'b1, 3'h7, BASE, 4'hf, 36'h0);
    look(1'b0, 36'h0);
    $display("turnaround test done");
  endtask : t_turn
  task automatic t_burst(input logic ord);
    ctl_model_i.burst_order_select = 1'b0;
    ctl_model_i.cyc(1'b0, 1'b0, SEL, BASE, 4'h0, 36'h0);
    for (int i = 0; i < 4; i++) ctl_model_i.cyc(1'b1, 1'b0, SEL, BASE, 4'h0, wv(i));
    ctl_model_i.burst_order_select = ord;
    ctl_model_i.cyc(1'b0, 1'b1, SEL, BASE + 17'h1, 4'hf, 36'h0);
    for (int n = 0; n < 5; n++) begin
      ctl_model_i.cyc(1'b1, 1'b1, SEL, BASE, 4'hf, 36'h0);
      look(n < 4, wv(ord ? (n ^ 1) : ((n + 1) % 4)));
    end
    $display("burst test done");
  endtask : t_burst
  task automatic t_lanes();
    ctl_model_i.cyc(1'b0, 1'b0, SEL, BASE, 4'h5, 36'h0);
    ctl_model_i.cyc(1'b0, 1'b1, SEL, BASE, 4'hf, 36'hf_ffff_ffff);
    ctl_model_i.cyc(1'b0, 1'b1, 3'h7, BASE, 4'h0, 36'h0);
    look(1'b1, 36'hb_ff00_ffa0);
    $display("byte lane test done");
  endtask : t_lanes
  task automatic t_stall();
    ctl_model_i.cyc(1'b0, 1'b1, SEL, BASE + 17'h2, 4'hf, 36'h0);
    ctl_model_i.stall();
    look(1'b1, wv(2));
    ctl_model_i.stall();
    look(1'b1, wv(2));
    out_enable_n = 1'b1;
    look(1'b0, 36'h0);
    out_enable_n = 1'b0;
    ctl_model_i.cyc(1'b0, 1'b1, 3'h7, BASE, 4'hf, 36'h0);
    look(1'b1, wv(2));
    ctl_model_i.cyc(1'b1, 1'b1, SEL, BASE, 4'hf, 36'h0);
    look(1'b0, 36'h0);
    $display("stall test done");
  endtask : t_stall
  task automatic t_desel();
    for (int k = 0; k < 3; k++) begin
      ctl_model_i.cyc(1'b0, 1'b1, SEL, BASE + 17'h3, 4'hf, 36'h0);
      ctl_model_i.cyc(1'b0, 1'b1, SEL ^ (3'h1 << k), BASE, 4'hf, 36'h0);
      look(1'b1, wv(3));
      ctl_model_i.cyc(1'b1, 1'b1, SEL, BASE, 4'hf, 36'h0);
      look(1'b0, 36'h0);
    end
    $display("deselect test done");
  endtask : t_desel
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 500) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    t_turn();
    t_burst(1'b0);
    t_burst(1'b1);
    t_lanes();
    t_stall();
    t_desel();
    give_verdict();
  end
endmodule : sync_burst_sram_port_tb_top
